// >>> logic/usdp_dma_pins.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "usdp_defines.svh"
module usdp_dma_pins #(
  parameter int DEPTH = 16
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       masterResetIn,
  input  wire logic       chipSelect,
  input  wire logic       writeStrobeHi,
  input  wire logic       writeStrobeLoN,
  input  wire logic       readStrobeHi,
  input  wire logic       readStrobeLoN,
  input  wire logic [2:0] address,
  input  wire logic [7:0] writeData,
  output logic      [7:0] readData,
  input  wire logic       rxCharValid,
  input  wire logic [7:0] rxChar,
  input  wire logic       rxTimeout,
  input  wire logic       txTake,
  input  wire logic       txBitIn,
  output logic      [7:0] txChar,
  output logic            txValid,
  output logic            rtsN,
  output logic            serialLineOut,
  output logic            rxDmaReadyN,
  output logic            txDmaReadyN
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [CW-1:0] trigLevel(input logic [1:0] sel);
    case (sel)
      2'h0:    trigLevel = CW'(`USDP_TRIG_L0);
      2'h1:    trigLevel = CW'(`USDP_TRIG_L1);
      2'h2:    trigLevel = CW'(`USDP_TRIG_L2);
      default: trigLevel = CW'(`USDP_TRIG_L3);
    endcase
  endfunction

  function automatic logic [CW-1:0] capacity(input logic fifoOn);
    capacity = fifoOn ? CW'(DEPTH) : CW'(1);
  endfunction

  // ----------------------------------------------------------
  // Master reset synchroniser
  // ----------------------------------------------------------
  logic mrMeta;
  logic mrSync;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mrMeta <= 1'b1;
      mrSync <= 1'b1;
    end
    else
    begin
      mrMeta <= masterResetIn;
      mrSync <= mrMeta;
    end
  end

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  logic [7:0]          fifoCtl, next_fifoCtl;
  logic [7:0]          modemCtl, next_modemCtl;
  logic                overrun, next_overrun;
  logic [PW-1:0]       rxRd, next_rxRd, rxWr, next_rxWr;
  logic [CW-1:0]       rxCount, next_rxCount;
  logic [PW-1:0]       txRd, next_txRd, txWr, next_txWr;
  logic [CW-1:0]       txCount, next_txCount;
  usdp_pkg::usdp_rxreq_t rxReq, next_rxReq;
  logic [7:0]          next_readData, next_txChar;
  logic                next_txValid, next_rtsN, next_serial_line_out;
  logic                next_rxDmaReadyN, next_txDmaReadyN;
  logic [7:0]          rxMem [DEPTH];
  logic [7:0]          txMem [DEPTH];
  logic                wrEn, rdEn, rxPush, rxPop, txPush, txPop;
  logic                fifoOn;
  usdp_pkg::usdp_dma_t dmaMode;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb
  begin
    wrEn = chipSelect && (writeStrobeHi || !writeStrobeLoN);
    rdEn = chipSelect && (readStrobeHi || !readStrobeLoN);
    fifoOn = fifoCtl[`USDP_FIFO_EN];
    dmaMode = (fifoOn && fifoCtl[`USDP_FIFO_DMA]) ?
              usdp_pkg::USDP_DMA_MULTI : usdp_pkg::USDP_DMA_SINGLE;
    rxPush = rxCharValid && (rxCount < capacity(fifoOn));
    rxPop = rdEn && address == `USDP_OFS_DATA && rxCount != '0;
    txPush = wrEn && address == `USDP_OFS_DATA && (txCount < capacity(fifoOn));
    txPop = txTake && txCount != '0;
    next_fifoCtl = fifoCtl;
    next_modemCtl = modemCtl;
    next_overrun = overrun;
    next_rxRd = rxRd;
    next_rxWr = rxWr;
    next_txRd = txRd;
    next_txWr = txWr;
    next_rxCount = rxCount;
    next_txCount = txCount;
    next_rxReq = rxReq;
    next_readData = 8'h00;
    if (rdEn && address == `USDP_OFS_STATUS)
    begin
      next_overrun = 1'b0;
    end
    if (rxCharValid && !rxPush)
    begin
      next_overrun = 1'b1;
    end
    if (rxPush)
    begin
      next_rxWr = PW'(rxWr + 1'b1);
    end
    if (rxPop)
    begin
      next_rxRd = PW'(rxRd + 1'b1);
    end
    next_rxCount = CW'(rxCount + CW'(rxPush) - CW'(rxPop));
    if (txPush)
    begin
      next_txWr = PW'(txWr + 1'b1);
    end
    if (txPop)
    begin
      next_txRd = PW'(txRd + 1'b1);
    end
    next_txCount = CW'(txCount + CW'(txPush) - CW'(txPop));
    if (wrEn && address == `USDP_OFS_MODEM)
    begin
      next_modemCtl = writeData;
    end
    if (wrEn && address == `USDP_OFS_FIFO)
    begin
      next_fifoCtl = {writeData[7:3], 2'h0, writeData[0]};
      if (writeData[`USDP_FIFO_RXCLR] || writeData[0] != fifoOn)
      begin
        next_rxRd = '0;
        next_rxWr = '0;
        next_rxCount = '0;
      end
      if (writeData[`USDP_FIFO_TXCLR] || writeData[0] != fifoOn)
      begin
        next_txRd = '0;
        next_txWr = '0;
        next_txCount = '0;
      end
    end
    if (rdEn)
    begin
      case (address)
        `USDP_OFS_DATA:   next_readData = (rxCount != '0) ? rxMem[rxRd] : 8'h00;
        `USDP_OFS_FIFO:   next_readData = fifoCtl;
        `USDP_OFS_MODEM:  next_readData = modemCtl;
        `USDP_OFS_STATUS:
        begin
          next_readData[`USDP_STAT_READY] = rxCount != '0;
          next_readData[`USDP_STAT_OVERRUN] = overrun;
          next_readData[`USDP_STAT_TXEMPTY] = txCount == '0;
        end
        default:          next_readData = 8'h00;
      endcase
    end
    // The burst request is armed by trigger or timeout and held until empty or until mode 1 is left.
    case (rxReq)
      usdp_pkg::USDP_RQ_IDLE:
        if (dmaMode == usdp_pkg::USDP_DMA_MULTI && rxCount != '0 &&
            (rxCount >= trigLevel(fifoCtl[`USDP_FIFO_TRIG +: 2]) || rxTimeout))
        begin
          next_rxReq = usdp_pkg::USDP_RQ_BURST;
        end
      usdp_pkg::USDP_RQ_BURST:
        if (rxCount == '0 || dmaMode != usdp_pkg::USDP_DMA_MULTI)
        begin
          next_rxReq = usdp_pkg::USDP_RQ_IDLE;
        end
      default: next_rxReq = usdp_pkg::USDP_RQ_IDLE;
    endcase
    if (dmaMode == usdp_pkg::USDP_DMA_SINGLE)
    begin
      next_rxDmaReadyN = rxCount == '0;
      next_txDmaReadyN = txCount != '0;
    end
    else
    begin
      // Ready is released on the clock after the store empties, even while the burst state is still set.
      next_rxDmaReadyN = !(rxCount != '0 && (rxReq == usdp_pkg::USDP_RQ_BURST ||
        rxCount >= trigLevel(fifoCtl[`USDP_FIFO_TRIG +: 2]) || rxTimeout));
      next_txDmaReadyN = txCount >= CW'(DEPTH);
    end
    next_rtsN = !(modemCtl[`USDP_MODEM_RTS] && !modemCtl[`USDP_MODEM_LOOP]);
    next_serial_line_out = modemCtl[`USDP_MODEM_LOOP] ? 1'b1 : txBitIn;
    next_txChar = (txCount != '0) ? txMem[txRd] : 8'h00;
    next_txValid = txCount != '0;
    if (mrSync)
    begin
      next_fifoCtl = `USDP_FIFO_RST;
      next_modemCtl = `USDP_MODEM_RST;
      next_overrun = 1'b0;
      next_rxRd = '0;
      next_rxWr = '0;
      next_rxCount = '0;
      next_txRd = '0;
      next_txWr = '0;
      next_txCount = '0;
      next_rxReq = usdp_pkg::USDP_RQ_IDLE;
      next_rtsN = 1'b1;
      next_serial_line_out = 1'b1;
      next_rxDmaReadyN = 1'b1;
      next_txDmaReadyN = 1'b0;
      next_txValid = 1'b0;
      next_txChar = 8'h00;
    end
  end

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fifoCtl <= `USDP_FIFO_RST;
      modemCtl <= `USDP_MODEM_RST;
      overrun <= 1'b0;
      rxRd <= '0;
      rxWr <= '0;
      rxCount <= '0;
      txRd <= '0;
      txWr <= '0;
      txCount <= '0;
      rxReq <= usdp_pkg::USDP_RQ_IDLE;
      readData <= 8'h00;
      txChar <= 8'h00;
      txValid <= 1'b0;
      rtsN <= 1'b1;
      serialLineOut <= 1'b1;
      rxDmaReadyN <= 1'b1;
      txDmaReadyN <= 1'b0;
    end
    else
    begin
      fifoCtl <= next_fifoCtl;
      modemCtl <= next_modemCtl;
      overrun <= next_overrun;
      rxRd <= next_rxRd;
      rxWr <= next_rxWr;
      rxCount <= next_rxCount;
      txRd <= next_txRd;
      txWr <= next_txWr;
      txCount <= next_txCount;
      rxReq <= next_rxReq;
      readData <= next_readData;
      txChar <= next_txChar;
      txValid <= next_txValid;
      rtsN <= next_rtsN;
      serialLineOut <= next_serial_line_out;
      rxDmaReadyN <= next_rxDmaReadyN;
      txDmaReadyN <= next_txDmaReadyN;
    end
  end

  // Character storage carries no reset; pointers define what is valid.
  always_ff @(posedge clk)
  begin
    if (rxPush)
    begin
      rxMem[rxWr] <= rxChar;
    end
    if (txPush)
    begin
      txMem[txWr] <= writeData;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  sequence modemWrite;
    wrEn && address == `USDP_OFS_MODEM && !mrSync;
  endsequence

  rts_active_a: assert property (@(posedge clk) disable iff (!arst_n)
    !mrSync && modemCtl[`USDP_MODEM_RTS] && !modemCtl[`USDP_MODEM_LOOP] |=> !rtsN)
    else $error("rts not driven active");
  rts_inactive_a: assert property (@(posedge clk) disable iff (!arst_n)
    (mrSync || modemCtl[`USDP_MODEM_LOOP] || !modemCtl[`USDP_MODEM_RTS]) |=> rtsN)
    else $error("rts not held inactive");
  mode_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    dmaMode == usdp_pkg::USDP_DMA_MULTI |-> fifoCtl[`USDP_FIFO_EN])
    else $error("multi mode without fifo");
  rx_single_a: assert property (@(posedge clk) disable iff (!arst_n)
    !mrSync && dmaMode == usdp_pkg::USDP_DMA_SINGLE |=> rxDmaReadyN == ($past(rxCount) == '0))
    else $error("mode 0 rx ready wrong");
  rx_burst_a: assert property (@(posedge clk) disable iff (!arst_n)
    !mrSync && dmaMode == usdp_pkg::USDP_DMA_MULTI && rxReq == usdp_pkg::USDP_RQ_BURST && rxCount != '0
    |=> !rxDmaReadyN)
    else $error("burst rx ready dropped");
  rx_empty_a: assert property (@(posedge clk) disable iff (!arst_n)
    !mrSync && rxCount == '0 |=> rxDmaReadyN)
    else $error("rx ready held while empty");
  rx_trigger_a: assert property (@(posedge clk) disable iff (!arst_n)
    !mrSync && dmaMode == usdp_pkg::USDP_DMA_MULTI && rxCount != '0 &&
    rxCount >= trigLevel(fifoCtl[`USDP_FIFO_TRIG +: 2]) |=> !rxDmaReadyN)
    else $error("trigger did not raise rx ready");
  tx_ready_a: assert property (@(posedge clk) disable iff (!arst_n)
    !mrSync && dmaMode == usdp_pkg::USDP_DMA_MULTI |=> txDmaReadyN == ($past(txCount) >= CW'(DEPTH)))
    else $error("mode 1 tx ready wrong");
  tx_single_a: assert property (@(posedge clk) disable iff (!arst_n)
    !mrSync && dmaMode == usdp_pkg::USDP_DMA_SINGLE |=> txDmaReadyN == ($past(txCount) != '0))
    else $error("mode 0 tx ready wrong");
  serial_line_out_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
    mrSync |=> serialLineOut && rtsN && rxDmaReadyN)
    else $error("master reset levels wrong");
  modem_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    modemWrite |=> modemCtl == $past(writeData))
    else $error("modem write lost");
  status_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    rdEn && address == `USDP_OFS_STATUS |=> readData[`USDP_STAT_TXEMPTY] == ($past(txCount) == '0))
    else $error("status read wrong");
endmodule // usdp_dma_pins

// >>> logic/usdp_defines.svh
`ifndef USDP_DEFINES_SVH
`define USDP_DEFINES_SVH
// Function
// - Request-to-send follows modem bit outside loop mode, high otherwise
// - DMA type selectable only in FIFO mode
// - Mode 0 receive ready while characters held
// - Mode 1 receive ready from trigger until empty
// - Mode 1 receive requests continue until emptied
// - Transmit mode 1 requests until FIFO full
// - Master reset drives serial output high
// - Write taken on either write strobe polarity
// - Master reset clears registers and outputs except read data
// - Read taken on either read strobe polarity

// ----------------------------------------------------------
// Register offsets
// ----------------------------------------------------------
`define USDP_OFS_DATA     3'h0
`define USDP_OFS_FIFO     3'h2
`define USDP_OFS_MODEM    3'h4
`define USDP_OFS_STATUS   3'h5

// ----------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------
`define USDP_FIFO_EN      0
`define USDP_FIFO_RXCLR   1
`define USDP_FIFO_TXCLR   2
`define USDP_FIFO_DMA     3
`define USDP_FIFO_TRIG    6
`define USDP_MODEM_RTS    1
`define USDP_MODEM_LOOP   4
`define USDP_STAT_READY   0
`define USDP_STAT_OVERRUN 1
`define USDP_STAT_TXEMPTY 5
`define USDP_FIFO_RST     8'h00
`define USDP_MODEM_RST    8'h00

// ----------------------------------------------------------
// Receive trigger levels in characters
// ----------------------------------------------------------
`define USDP_TRIG_L0      1
`define USDP_TRIG_L1      4
`define USDP_TRIG_L2      8
`define USDP_TRIG_L3      14

`endif

// >>> logic/usdp_pkg.sv
package usdp_pkg;
  typedef enum logic [0:0] {
    USDP_RQ_IDLE  = 1'b0,
    USDP_RQ_BURST = 1'b1
  } usdp_rxreq_t;
  typedef enum logic [0:0] {
    USDP_DMA_SINGLE = 1'b0,
    USDP_DMA_MULTI  = 1'b1
  } usdp_dma_t;
endpackage

// >>> dv/usdp_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial-side receiver and transmitter stand-in.
// ----------------------------------------
module usdp_far_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] req,
  input  wire logic [7:0] sendChar,
  output logic            rxCharValid,
  output logic      [7:0] rxChar,
  output logic            rxTimeout,
  output logic            txTake,
  output logic            txBitIn
);
  // Between deliveries the character lines invert on every clock, so they alternate between the last delivered value and its inverse.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxCharValid <= 1'b0;
      rxChar      <= 8'h00;
      rxTimeout   <= 1'b0;
      txTake      <= 1'b0;
      txBitIn     <= 1'b1;
    end
    else
    begin
      rxCharValid <= (req == 2'h1);
      rxChar      <= (req == 2'h1) ? sendChar : ~rxChar;
      txTake      <= (req == 2'h2);
      rxTimeout   <= (req == 2'h3);
      txBitIn     <= ~txBitIn;
    end
  end
endmodule // usdp_far_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int DEPTH = 16;
  logic clk, arst_n, masterResetIn, chipSelect, writeStrobeHi, writeStrobeLoN;
  logic readStrobeHi, readStrobeLoN, rxCharValid, rxTimeout, txTake, txBitIn;
  logic [2:0] address;
  logic [7:0] writeData, readData, rxChar, txChar, sendChar, modem;
  logic [1:0] req;
  logic txValid, rtsN, serialLineOut, rxDmaReadyN, txDmaReadyN;
  int failures, check_count, trig, rxQ[$], txQ[$];
  bit fen, dma, rxAct;

  usdp_dma_pins #(.DEPTH(DEPTH)) u_usdp_dma_pins (.clk(clk), .arst_n(arst_n), .masterResetIn(masterResetIn),
    .chipSelect(chipSelect), .writeStrobeHi(writeStrobeHi), .writeStrobeLoN(writeStrobeLoN),
    .readStrobeHi(readStrobeHi), .readStrobeLoN(readStrobeLoN), .address(address), .writeData(writeData),
    .readData(readData), .rxCharValid(rxCharValid), .rxChar(rxChar), .rxTimeout(rxTimeout), .txTake(txTake),
    .txBitIn(txBitIn), .txChar(txChar), .txValid(txValid), .rtsN(rtsN), .serialLineOut(serialLineOut),
    .rxDmaReadyN(rxDmaReadyN), .txDmaReadyN(txDmaReadyN));
  usdp_far_model u_usdp_far_model (.clk(clk), .arst_n(arst_n), .req(req), .sendChar(sendChar),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .rxTimeout(rxTimeout), .txTake(txTake), .txBitIn(txBitIn));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Checking and bus tasks.
  // ----------------------------------------
  task automatic test_done();
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    int n;
    logic eRts, eRx, eTx;
    eRts = !(modem[1] && !modem[4]);
    eRx = (fen && dma) ? !rxAct : (rxQ.size() == 0);
    eTx = (fen && dma) ? (txQ.size() == (fen ? DEPTH : 1)) : (txQ.size() != 0);
    n = 0;
    repeat (3) @(posedge clk);
    #1;
    while (n < 6 && {rtsN, rxDmaReadyN, txDmaReadyN} !== {eRts, eRx, eTx})
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 6)
    begin
      failures++;
      test_done();
    end
    else
    begin
      check({7'h00, rtsN}, {7'h00, eRts});
      check({7'h00, rxDmaReadyN}, {7'h00, eRx});
      check({7'h00, txDmaReadyN}, {7'h00, eTx});
      check({7'h00, serialLineOut}, {7'h00, ((modem[4] || masterResetIn) ? 1'b1 : !txBitIn)});
      check({7'h00, txValid}, {7'h00, txQ.size() != 0});
      if (txQ.size() != 0)
        check(txChar, 8'(txQ[0]));
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d, input bit lo, input bit cs);
    @(posedge clk);
    chipSelect <= cs;
    address <= a;
    writeData <= d;
    if (lo)
      writeStrobeLoN <= 1'b0;
    else
      writeStrobeHi <= 1'b1;
    @(posedge clk);
    chipSelect <= 1'b0;
    writeStrobeLoN <= 1'b1;
    writeStrobeHi <= 1'b0;
    if (cs && a == 3'h4)
      modem = d;
    if (cs && a == 3'h2)
    begin
      if (d[0] != fen || d[1])
        rxQ.delete();
      if (d[0] != fen || d[2])
        txQ.delete();
      fen = d[0];
      dma = d[3];
      trig = (d[7:6] == 2'h0) ? 1 : (d[7:6] == 2'h1) ? 4 : (d[7:6] == 2'h2) ? 8 : 14;
      rxAct = (rxAct || rxQ.size() >= trig) && d[0] && d[3] && rxQ.size() != 0;
    end
    if (cs && a == 3'h0 && txQ.size() < (fen ? DEPTH : 1))
      txQ.push_back(d);
  endtask

  task automatic rd(input logic [2:0] a, input bit lo, input logic [7:0] exp);
    @(posedge clk);
    chipSelect <= 1'b1;
    address <= a;
    if (lo)
      readStrobeLoN <= 1'b0;
    else
      readStrobeHi <= 1'b1;
    @(posedge clk);
    chipSelect <= 1'b0;
    readStrobeLoN <= 1'b1;
    readStrobeHi <= 1'b0;
    #1;
    check(readData, exp);
  endtask

  task automatic pop(input bit lo);
    int c;
    c = rxQ.pop_front();
    if (rxQ.size() == 0)
      rxAct = 1'b0;
    rd(3'h0, lo, c[7:0]);
    settle();
  endtask

  task automatic far(input logic [1:0] k);
    @(posedge clk);
    req <= k;
    sendChar <= 8'($urandom);
    @(posedge clk);
    req <= 2'h0;
    if (k == 2'h1 && rxQ.size() < (fen ? DEPTH : 1))
      rxQ.push_back(sendChar);
    if (k == 2'h2 && txQ.size() > 0)
      void'(txQ.pop_front());
    if (fen && dma && rxQ.size() > 0 && (k == 2'h3 || rxQ.size() >= trig))
      rxAct = 1'b1;
    settle();
  endtask

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial
  begin
    {arst_n, masterResetIn, chipSelect, writeStrobeHi, readStrobeHi, req} = '0;
    {writeStrobeLoN, readStrobeLoN} = 2'h3;
    {address, writeData, sendChar, modem} = '0;
    {failures, check_count, fen, dma, rxAct, trig} = '0;
    void'($urandom(32'h47ee));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    check({7'h00, serialLineOut}, 8'h01);
    wr(3'h4, 8'h02, 1'b0, 1'b1); settle();
    wr(3'h4, 8'h12, 1'b1, 1'b1); settle();
    wr(3'h4, 8'h00, 1'b0, 1'b1); settle();
    wr(3'h4, 8'h02, 1'b1, 1'b0); settle();
    wr(3'h4, 8'h02, 1'b1, 1'b1); settle();
    wr(3'h2, 8'h08, 1'b0, 1'b1); settle();
    far(2'h1); far(2'h1); pop(1'b1);
    rd(3'h5, 1'b0, 8'h22);
    rd(3'h5, 1'b1, 8'h20);
    rd(3'h7, 1'b0, 8'h00);
    repeat (2) wr(3'h0, 8'($urandom), 1'b0, 1'b1);
    settle();
    far(2'h2);
    wr(3'h2, 8'h01, 1'b1, 1'b1); settle();
    far(2'h1); pop(1'b0);
    wr(3'h0, 8'h5a, 1'b0, 1'b1); settle(); far(2'h2);
    wr(3'h2, 8'h4f, 1'b0, 1'b1); settle();
    repeat (4) far(2'h1);
    repeat (4) pop(1'b1);
    far(2'h1); far(2'h3); pop(1'b0);
    repeat (DEPTH + 1)
    begin
      wr(3'h0, 8'($urandom), 1'b1, 1'b1);
      settle();
    end
    far(2'h2); far(2'h1);
    wr(3'h4, 8'h02, 1'b0, 1'b1);
    masterResetIn <= 1'b1;
    {modem, fen, dma, rxAct} = '0;
    rxQ.delete();
    txQ.delete();
    repeat (4) @(posedge clk);
    repeat (3)
    begin
      @(posedge clk);
      #1;
      check({7'h00, serialLineOut}, 8'h01);
    end
    settle();
    @(posedge clk);
    masterResetIn <= 1'b0;
    settle();
    test_done();
  end
endmodule // testbench
